/* File: design/fpec_map.vh */
// flash program/erase control: constants for the control block
// assumes inclusion by design files only; no logic here
`ifndef FPEC_MAP_VH
`define FPEC_MAP_VH
`define FPEC_ADDR_W 24
`define FPEC_PAGE_BYTES 128
`define FPEC_PAGE_IDX_W 7
`define FPEC_BLK_W 16
`define FPEC_ERASED_BYTE 8'hFF
`define FPEC_CTL1_RST 8'h00
`define FPEC_CTL2_RST 8'h00
`define FPEC_EBR_RST 8'h00
`define FPEC_MODE_IDLE 3'h0
`define FPEC_MODE_PROG 3'h1
`define FPEC_MODE_PVER 3'h2
`define FPEC_MODE_ERASE 3'h3
`define FPEC_MODE_EVER 3'h4
`endif

/* File: design/fpec_page_latch.v */
// flash program/erase control: 128-byte page data latch
// assumes byte writes arrive one per cycle from the control block
`timescale 1ns/1ps
`include "fpec_map.vh"
module fpec_page_latch (
	core_clk,
	reset,
	clr,
	wr_en,
	wr_idx,
	wr_data,
	rd_idx,
	rd_data
);
	input wire core_clk;
	input wire reset;
	input wire clr;
	input wire wr_en;
	input wire [`FPEC_PAGE_IDX_W-1:0] wr_idx;
	input wire [7:0] wr_data;
	input wire [`FPEC_PAGE_IDX_W-1:0] rd_idx;
	output wire [7:0] rd_data;

	reg [7:0] mem_r [0:`FPEC_PAGE_BYTES-1];
	genvar g;
	generate
		for (g = 0; g < `FPEC_PAGE_BYTES; g = g + 1) begin : gen_byte
			always @(posedge core_clk or posedge reset) begin
				if (reset) begin
					mem_r[g] <= `FPEC_ERASED_BYTE;
				end else if (clr) begin
					mem_r[g] <= `FPEC_ERASED_BYTE;
				end else if (wr_en && wr_idx == g) begin
					mem_r[g] <= wr_data;
				end
			end
		end
	endgenerate
	assign rd_data = mem_r[rd_idx];
endmodule

/* File: design/fpec_ctrl.v */
// flash program/erase control: modes, page latch, protection, error flag
// assumes cpu bus strobes on core_clk; standby level from another domain
//
// Summary of operation
// - one of four modes from control one
// - latch page address and 128 bytes
// - program pulse only while program bit set
// - erase pulse only while erase bit set
// - dummy write FF, then word verify reads
// - erase needs no prewrite to zero
// - block all interrupts during pulse or boot
// - reset or standby aborts and clears registers
// - write enable clear blocks program and erase
// - unselected blocks protected; all zero protects all
// - ram overlay select inhibits program and erase
// - error events during pulse set error flag
// - error keeps registers, aborts, allows verify only
// - only reset or standby clears error flag
// - flash reads during pulse return undefined
`timescale 1ns/1ps
`include "fpec_map.vh"
module fpec_ctrl (
	core_clk,
	reset,
	standby_req,
	software_write_enable_bit,
	program_pulse_bit,
	erase_pulse_bit,
	program_verify_bit,
	erase_verify_bit,
	erase_block_select_low,
	erase_block_select_high,
	ram_overlay_select,
	boot_running,
	flash_wr,
	flash_rd,
	flash_addr,
	flash_wdata,
	exception_taken,
	sleep_exec,
	bus_lost,
	irq_in,
	nmi_in,
	array_rdata,
	mode,
	page_addr,
	page_idx,
	page_byte,
	array_prog,
	array_erase,
	array_erase_blocks,
	verify_active,
	verify_addr,
	flash_rdata,
	flash_error_flag,
	irq_out,
	nmi_out
);
	input wire core_clk;
	input wire reset;
	input wire standby_req;
	input wire software_write_enable_bit;
	input wire program_pulse_bit;
	input wire erase_pulse_bit;
	input wire program_verify_bit;
	input wire erase_verify_bit;
	input wire [7:0] erase_block_select_low;
	input wire [7:0] erase_block_select_high;
	input wire ram_overlay_select;
	input wire boot_running;
	input wire flash_wr;
	input wire flash_rd;
	input wire [`FPEC_ADDR_W-1:0] flash_addr;
	input wire [7:0] flash_wdata;
	input wire exception_taken;
	input wire sleep_exec;
	input wire bus_lost;
	input wire irq_in;
	input wire nmi_in;
	input wire [15:0] array_rdata;
	output reg [2:0] mode;
	output reg [`FPEC_ADDR_W-1:0] page_addr;
	input wire [`FPEC_PAGE_IDX_W-1:0] page_idx;
	output wire [7:0] page_byte;
	output reg array_prog;
	output reg array_erase;
	output reg [`FPEC_BLK_W-1:0] array_erase_blocks;
	output reg verify_active;
	output reg [`FPEC_ADDR_W-1:0] verify_addr;
	output reg [15:0] flash_rdata;
	output reg flash_error_flag;
	output reg irq_out;
	output reg nmi_out;

	// register images, cleared by reset or standby
	reg ctl_swe_r;
	reg ctl_p_r;
	reg ctl_e_r;
	reg ctl_pv_r;
	reg ctl_ev_r;
	reg [`FPEC_BLK_W-1:0] ebr_r;
	reg ram_overlay_select_r;
	reg sby_m_r;
	reg sby_r;
	reg [`FPEC_PAGE_IDX_W-1:0] wr_cnt_r;
	reg page_open_r;
	wire latch_wr;
	wire pulse_on;
	wire err_evt;
	wire [2:0] mode_nxt;

	function [2:0] fpec_mode_sel;
		input p;
		input e;
		input pv;
		input ev;
		begin
			if (p)
				fpec_mode_sel = `FPEC_MODE_PROG;
			else if (e)
				fpec_mode_sel = `FPEC_MODE_ERASE;
			else if (pv)
				fpec_mode_sel = `FPEC_MODE_PVER;
			else if (ev)
				fpec_mode_sel = `FPEC_MODE_EVER;
			else
				fpec_mode_sel = `FPEC_MODE_IDLE;
		end
	endfunction

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sby_m_r <= 1'b0;
			sby_r <= 1'b0;
		end else begin
			sby_m_r <= standby_req;
			sby_r <= sby_m_r;
		end
	end

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctl_swe_r <= 1'b0;
			ctl_p_r <= 1'b0;
			ctl_e_r <= 1'b0;
			ctl_pv_r <= 1'b0;
			ctl_ev_r <= 1'b0;
			ebr_r <= {`FPEC_EBR_RST, `FPEC_EBR_RST};
			ram_overlay_select_r <= 1'b0;
		end else if (sby_r) begin
			ctl_swe_r <= 1'b0;
			ctl_p_r <= 1'b0;
			ctl_e_r <= 1'b0;
			ctl_pv_r <= 1'b0;
			ctl_ev_r <= 1'b0;
			ebr_r <= {`FPEC_EBR_RST, `FPEC_EBR_RST};
			ram_overlay_select_r <= 1'b0;
		end else begin
			ctl_swe_r <= software_write_enable_bit;
			ctl_p_r <= program_pulse_bit;
			ctl_e_r <= erase_pulse_bit;
			ctl_pv_r <= program_verify_bit;
			ctl_ev_r <= erase_verify_bit;
			ebr_r <= {erase_block_select_high, erase_block_select_low};
			ram_overlay_select_r <= ram_overlay_select;
		end
	end

	// pulse may run only with write enable, no overlay, no error
	assign pulse_on = ctl_swe_r && !ram_overlay_select_r && !flash_error_flag;
	assign mode_nxt = fpec_mode_sel(ctl_p_r && pulse_on, ctl_e_r && pulse_on,
		ctl_pv_r, ctl_ev_r);
	assign err_evt = (mode == `FPEC_MODE_PROG || mode == `FPEC_MODE_ERASE) &&
		(flash_rd || exception_taken || sleep_exec || bus_lost);

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			flash_error_flag <= 1'b0;
		end else if (sby_r) begin
			flash_error_flag <= 1'b0;
		end else if (err_evt) begin
			flash_error_flag <= 1'b1;
		end
	end

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode <= `FPEC_MODE_IDLE;
			array_prog <= 1'b0;
			array_erase <= 1'b0;
			array_erase_blocks <= {`FPEC_BLK_W{1'b0}};
			verify_active <= 1'b0;
			irq_out <= 1'b0;
			nmi_out <= 1'b0;
		end else if (sby_r || err_evt) begin
			mode <= `FPEC_MODE_IDLE;
			array_prog <= 1'b0;
			array_erase <= 1'b0;
			array_erase_blocks <= {`FPEC_BLK_W{1'b0}};
			verify_active <= 1'b0;
			irq_out <= 1'b0;
			nmi_out <= 1'b0;
		end else begin
			mode <= mode_nxt;
			array_prog <= mode_nxt == `FPEC_MODE_PROG;
			array_erase <= mode_nxt == `FPEC_MODE_ERASE && ebr_r != 16'h0000;
			array_erase_blocks <= (mode_nxt == `FPEC_MODE_ERASE) ? ebr_r :
				{`FPEC_BLK_W{1'b0}};
			verify_active <= mode_nxt == `FPEC_MODE_PVER ||
				mode_nxt == `FPEC_MODE_EVER;
			irq_out <= irq_in && !ctl_p_r && !ctl_e_r && !boot_running;
			nmi_out <= nmi_in && !ctl_p_r && !ctl_e_r && !boot_running;
		end
	end

	// page capture: first byte sets address, then consecutive bytes
	assign latch_wr = flash_wr && !ctl_p_r && !ctl_e_r && !ctl_pv_r && !ctl_ev_r &&
		ctl_swe_r;
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			page_addr <= {`FPEC_ADDR_W{1'b0}};
			wr_cnt_r <= {`FPEC_PAGE_IDX_W{1'b0}};
			page_open_r <= 1'b0;
		end else if (sby_r) begin
			wr_cnt_r <= {`FPEC_PAGE_IDX_W{1'b0}};
			page_open_r <= 1'b0;
		end else if (latch_wr) begin
			if (!page_open_r) begin
				page_addr <= {flash_addr[`FPEC_ADDR_W-1:7], 7'h00};
				wr_cnt_r <= 7'h01;
				page_open_r <= 1'b1;
			end else begin
				wr_cnt_r <= wr_cnt_r + 7'h01;
				page_open_r <= wr_cnt_r != 7'h7F;
			end
		end
	end

	fpec_page_latch u_latch (
		.core_clk(core_clk),
		.reset(reset),
		.clr(sby_r),
		.wr_en(latch_wr),
		.wr_idx(flash_addr[`FPEC_PAGE_IDX_W-1:0]),
		.wr_data(flash_wdata),
		.rd_idx(page_idx),
		.rd_data(page_byte)
	);

	// verify address from dummy write, word read data
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			verify_addr <= {`FPEC_ADDR_W{1'b0}};
			flash_rdata <= 16'h0000;
		end else begin
			if (flash_wr && (ctl_pv_r || ctl_ev_r) && flash_addr[1:0] == 2'b00 &&
				flash_wdata == `FPEC_ERASED_BYTE)
				verify_addr <= flash_addr;
			if (flash_rd)
				flash_rdata <= (ctl_p_r || ctl_e_r) ? 16'hFFFF : array_rdata;
		end
	end
endmodule

/* File: testbench/fpec_array_model.sv */
// flash program/erase control: array word read model
// assumes the control block reads words at its verify address
`timescale 1ns/1ps
module fpec_array_model(
	input wire [23:0] verify_addr,
	output wire [15:0] array_rdata
);
	// data tied to the address so a stale address shows
	assign array_rdata = verify_addr[15:0] ^ 16'h5a5a;
endmodule

/* File: testbench/fpec_ctrl_asserts.sv */
// flash program/erase control: port checker
// assumes 2-edge control latency, standby held over 3 edges
`timescale 1ns/1ps
module fpec_ctrl_asserts(
	input wire core_clk,
	input wire reset,
	input wire standby_req,
	input wire software_write_enable_bit,
	input wire program_pulse_bit,
	input wire erase_pulse_bit,
	input wire ram_overlay_select,
	input wire flash_rd,
	input wire [2:0] mode,
	input wire array_prog,
	input wire array_erase,
	input wire [15:0] array_erase_blocks,
	input wire verify_active,
	input wire [15:0] flash_rdata,
	input wire flash_error_flag,
	input wire irq_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	prog_gate_a: assert property (array_prog |-> $past(software_write_enable_bit, 2)
		&& !$past(ram_overlay_select, 2)) else $error("prog gate");
	prog_pulse_a: assert property (array_prog |-> $past(program_pulse_bit, 2))
		else $error("prog pulse");
	erase_pulse_a: assert property (array_erase |-> $past(erase_pulse_bit, 2)
		&& array_erase_blocks != 16'h0000) else $error("erase pulse");
	irq_block_a: assert property (array_prog || array_erase |-> !irq_out)
		else $error("irq pass");
	err_set_a: assert property (array_prog && flash_rd |=> flash_error_flag && !array_prog)
		else $error("err set");
	err_keep_a: assert property (flash_error_flag && !standby_req |=> flash_error_flag)
		else $error("err lost");
	err_abort_a: assert property (flash_error_flag |-> !array_prog && !array_erase)
		else $error("err abort");
	prog_mode_a: assert property (array_prog |-> mode == 3'h1)
		else $error("prog mode");
	verify_mode_a: assert property (verify_active |-> !array_prog && !array_erase)
		else $error("verify mode");
	undef_read_a: assert property (array_prog && flash_rd |=> flash_rdata == 16'hffff)
		else $error("read data");
	cover property (array_prog);
	cover property (array_erase);
	cover property ($rose(flash_error_flag));
endmodule
bind fpec_ctrl fpec_ctrl_asserts chk (.core_clk(core_clk), .reset(reset),
	.standby_req(standby_req), .software_write_enable_bit(software_write_enable_bit),
	.program_pulse_bit(program_pulse_bit), .erase_pulse_bit(erase_pulse_bit),
	.ram_overlay_select(ram_overlay_select), .flash_rd(flash_rd), .mode(mode),
	.array_prog(array_prog), .array_erase(array_erase), .array_erase_blocks(array_erase_blocks),
	.verify_active(verify_active), .flash_rdata(flash_rdata),
	.flash_error_flag(flash_error_flag), .irq_out(irq_out));

/* File: testbench/flash_program_erase_control_tb.sv */
// flash program/erase control: self-checking testbench
// assumes fpec_ctrl timing of 2 edges from control to mode
`timescale 1ns/1ps
module flash_program_erase_control_tb;
	reg core_clk = 0, reset = 1, stby = 0, swe = 0, pp = 0, ep = 0, pv = 0, ev = 0;
	reg ovl = 0, boot = 0, wr = 0, rd = 0, irq = 1, nmi = 1;
	reg [2:0] evt = 0;
	reg [7:0] sel_lo = 0, sel_hi = 0, wdata = 0;
	reg [23:0] addr = 0;
	reg [6:0] idx = 0;
	wire [2:0] mode;
	wire [23:0] page_addr, verify_addr;
	wire [15:0] blocks, rdata, ardata;
	wire [7:0] pbyte;
	wire aprog, aerase, vact, err, irq_o, nmi_o;
	integer fails = 0, comparisons = 0, i;
	fpec_ctrl DUT (.core_clk(core_clk), .reset(reset), .standby_req(stby),
		.software_write_enable_bit(swe), .program_pulse_bit(pp), .erase_pulse_bit(ep),
		.program_verify_bit(pv), .erase_verify_bit(ev), .erase_block_select_low(sel_lo),
		.erase_block_select_high(sel_hi), .ram_overlay_select(ovl), .boot_running(boot),
		.flash_wr(wr), .flash_rd(rd), .flash_addr(addr), .flash_wdata(wdata),
		.exception_taken(evt[0]), .sleep_exec(evt[1]), .bus_lost(evt[2]), .irq_in(irq),
		.nmi_in(nmi), .array_rdata(ardata), .mode(mode), .page_addr(page_addr),
		.page_idx(idx), .page_byte(pbyte), .array_prog(aprog), .array_erase(aerase),
		.array_erase_blocks(blocks), .verify_active(vact), .verify_addr(verify_addr),
		.flash_rdata(rdata), .flash_error_flag(err), .irq_out(irq_o), .nmi_out(nmi_o));
	fpec_array_model arr (.verify_addr(verify_addr), .array_rdata(ardata));
	always #2.5 core_clk = ~core_clk;
	task tick(input integer n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task chk(input [8*10:1] what, input [23:0] exp, input [23:0] got);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("wrong value %0s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task end_sim;
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		tick(12);
		reset = 0;
		tick(1);
		chk("mode", 3'h0, mode);
		chk("page byte", 8'hff, pbyte);
		swe = 1;
		tick(1);
		wr = 1;
		for (i = 0; i < 128; i = i + 1) begin
			addr = 24'h00_0180 + i;
			wdata = i[7:0];
			tick(1);
		end
		wr = 0;
		idx = 7'h05;
		#1;
		chk("page addr", 24'h00_0180, page_addr);
		chk("page byte", 8'h05, pbyte);
		idx = 7'h00;
		#1;
		chk("page byte", 8'h00, pbyte);
		$display("test page done");
		swe = 0;
		pp = 1;
		tick(2);
		chk("prog off", 1'b0, aprog);
		swe = 1;
		ovl = 1;
		tick(2);
		chk("prog ovl", 1'b0, aprog);
		ovl = 0;
		tick(2);
		chk("prog on", 1'b1, aprog);
		chk("mode", 3'h1, mode);
		chk("irq", 1'b0, irq_o);
		chk("nmi", 1'b0, nmi_o);
		pp = 0;
		tick(2);
		chk("prog end", 1'b0, aprog);
		chk("irq", 1'b1, irq_o);
		boot = 1;
		tick(2);
		chk("irq boot", 1'b0, irq_o);
		boot = 0;
		ep = 1;
		tick(2);
		chk("erase none", 1'b0, aerase);
		sel_hi = 8'h04;
		tick(2);
		chk("erase on", 1'b1, aerase);
		chk("mode", 3'h3, mode);
		chk("blocks", 16'h0400, blocks);
		ep = 0;
		tick(2);
		chk("erase end", 1'b0, aerase);
		$display("test pulses done");
		pv = 1;
		tick(2);
		chk("mode", 3'h2, mode);
		addr = 24'h00_0104;
		wdata = 8'hff;
		wr = 1;
		tick(1);
		wr = 0;
		chk("verify", 1'b1, vact);
		chk("vaddr", 24'h00_0104, verify_addr);
		rd = 1;
		tick(1);
		rd = 0;
		chk("vdata", 16'h5b5e, rdata);
		addr = 24'h00_0106;
		wr = 1;
		tick(1);
		wr = 0;
		chk("vaddr", 24'h00_0104, verify_addr);
		pv = 0;
		$display("test verify done");
		for (i = 0; i < 4; i = i + 1) begin
			pp = 1;
			tick(2);
			if (i == 3)
				rd = 1;
			else
				evt = 3'b001 << i;
			tick(1);
			rd = 0;
			evt = 0;
			chk("error", 1'b1, err);
			chk("abort", 1'b0, aprog);
			if (i == 3)
				chk("undef", 16'hffff, rdata);
			pp = 0;
			tick(2);
			pp = 1;
			tick(2);
			chk("reentry", 1'b0, aprog);
			pp = 0;
			ev = 1;
			tick(2);
			chk("mode", 3'h4, mode);
			ev = 0;
			chk("sticky", 1'b1, err);
			stby = 1;
			tick(4);
			stby = 0;
			tick(2);
			chk("cleared", 1'b0, err);
		end
		$display("test errors done");
		pp = 1;
		tick(2);
		chk("prog again", 1'b1, aprog);
		reset = 1;
		tick(1);
		chk("rst abort", 1'b0, aprog);
		chk("mode", 3'h0, mode);
		pp = 0;
		reset = 0;
		tick(2);
		chk("prog off", 1'b0, aprog);
		$display("test reset done");
		end_sim;
	end
	initial begin
		#20000;
		fails = fails + 1;
		end_sim;
	end
endmodule
